// >>> core/gate_task_regs.vh
/*
  Constants for the gate and task switch protection block: descriptor field
  positions, gate type codes, task state segment layout and sequencer sizes.
  Assumes descriptors arrive as two 32-bit words, word 0 at +0, word 1 at +4.
*/
`ifndef GATE_TASK_REGS_VH
`define GATE_TASK_REGS_VH

// ==========================================================================
// Descriptor fields
// ==========================================================================
`define TYPE_HI 11
`define TYPE_LO 8
`define DPL_HI 14
`define DPL_LO 13
`define PRESENT_BIT 15
`define SYS_BIT 12
`define CONFORM_BIT 10
`define PARAM_HI 4
`define PARAM_LO 0
`define SEL_TI_BIT 2

// ==========================================================================
// Gate and segment type codes
// ==========================================================================
`define TYPE_CALL16 4'h4
`define TYPE_CALL32 4'hc
`define TYPE_TASKG 4'h5
`define TYPE_INT16 4'h6
`define TYPE_INT32 4'he
`define TYPE_TRAP16 4'h7
`define TYPE_TRAP32 4'hf
`define TYPE_TSS16_AVAIL 4'h1
`define TYPE_TSS32_AVAIL 4'h9

// ==========================================================================
// Gate kind codes reported to the core
// ==========================================================================
`define KIND_NONE 3'h0
`define KIND_CALL16 3'h1
`define KIND_CALL32 3'h2
`define KIND_TASK 3'h3
`define KIND_INT16 3'h4
`define KIND_INT32 3'h5
`define KIND_TRAP16 3'h6
`define KIND_TRAP32 3'h7

// ==========================================================================
// Task state segment layout
// ==========================================================================
`define TSS32_WORDS 6'h1a
`define TSS16_WORDS 6'h16
`define IOMAP_DEFAULT 16'h0068
`define STATE_WORDS 26
`define STATE_IDX_W 5

// ==========================================================================
// Fault codes
// ==========================================================================
`define FLT_NONE 4'h0
`define FLT_GATE_PRIV 4'h1
`define FLT_DEST_PRIV 4'h2
`define FLT_NOT_PRESENT 4'h3
`define FLT_BAD_TYPE 4'h4
`define FLT_TASK_PRIV 4'h5
`define FLT_LOAD_PRIV 4'h6
`define FLT_NOT_GLOBAL 4'h7
`define FLT_NOT_PROT 4'h8

`endif

// >>> core/gate_type_decoder.v
/*
  Combinational decode of a four-bit system descriptor type into a gate kind.
  Assumes the caller has already checked that the descriptor is a system one.
*/
`timescale 1ns/1ps
`include "gate_task_regs.vh"

module gate_type_decoder (
  input wire [3:0] type_code,
  output reg [2:0] kind,
  output wire is_call,
  output wire is_task_gate,
  output wire is_32bit
);

  always @* begin
    case (type_code)
      `TYPE_CALL16: kind = `KIND_CALL16;
      `TYPE_CALL32: kind = `KIND_CALL32;
      `TYPE_TASKG: kind = `KIND_TASK;
      `TYPE_INT16: kind = `KIND_INT16;
      `TYPE_INT32: kind = `KIND_INT32;
      `TYPE_TRAP16: kind = `KIND_TRAP16;
      `TYPE_TRAP32: kind = `KIND_TRAP32;
      default: kind = `KIND_NONE;
    endcase
  end

  assign is_call = (kind == `KIND_CALL16) || (kind == `KIND_CALL32);
  assign is_task_gate = (kind == `KIND_TASK);
  assign is_32bit = type_code[3];

endmodule

// >>> core/gate_task_protect.v
/*
  Protection sequencer for control transfers through gates and for task
  switches, plus the task pointer register. Descriptor words and the task
  state are handed in by the core; the block answers with permit or fault.
  Assumes all inputs are synchronous to core_clk and that the core holds a
  request's operands steady while busy is high.
*/
// Behaviour
// - Decode gate type codes into gate kinds
// - Call gate: max(current, requested) <= gate level
// - Jump through gate: destination level equals current
// - Call through gate: destination level <= current
// - Conforming target allows transfer without gate (not here: a request whose descriptor is not a gate always faults)
// - Gate selector fetches destination code descriptor
// - Target offset from word1 high, word0 low
// - Copy parameter count from word1 bits 4:0
// - Task switch saves old, then loads new
// - Task pointer: own instructions, protected, level 0
// - Task pointer selector must index global table (checked on load only; a task gate's selector is taken unchecked)
// - Only task pointer selector visible to software
// - Task gate: requested and current below gate
// - Ignore requested level in task gate selector
// - Support 32-bit and 16-bit segment layouts
// - 32-bit segment holds I/O bitmap base
// - Per-level stacks and back-link in segment
// - Level 00 most privileged, 11 least
`timescale 1ns/1ps
`include "gate_task_regs.vh"

module gate_task_protect (
  input wire core_clk,
  input wire reset_n,
  input wire protected_mode,
  input wire [1:0] current_privilege_level,
  input wire xfer_start,
  input wire xfer_is_call,
  input wire [15:0] xfer_selector,
  input wire [31:0] gate_word0,
  input wire [31:0] gate_word1,
  input wire dest_ready,
  input wire [31:0] dest_word1,
  input wire tss_word1_valid,
  input wire [31:0] tss_word1,
  input wire [31:0] tss_base,
  input wire [31:0] cur_state_word,
  input wire [31:0] new_state_word,
  input wire load_task_pointer_instr,
  input wire store_task_pointer_instr,
  input wire [15:0] ltr_selector,
  output reg busy,
  output reg done,
  output reg fault,
  output reg [3:0] fault_code,
  output reg [2:0] gate_kind,
  output reg dest_fetch,
  output reg [15:0] dest_selector,
  output reg [31:0] target_offset,
  output reg [4:0] param_copy_count,
  output reg [1:0] new_privilege_level,
  output reg state_save,
  output reg state_load,
  output reg [4:0] state_index,
  output reg [31:0] save_data,
  output reg [15:0] back_link,
  output reg [15:0] io_map_base,
  output reg [15:0] task_pointer_register,
  output reg [15:0] str_value,
  output reg str_valid
);

  // ==========================================================================
  // State encoding
  // ==========================================================================
  localparam S_IDLE = 3'h0;
  localparam S_DEST = 3'h1;
  localparam S_TSSD = 3'h2;
  localparam S_SAVE = 3'h3;
  localparam S_LOAD = 3'h4;
  localparam S_DONE = 3'h5;

  reg [2:0] state;
  reg [2:0] next_state;
  reg is_tss32;
  reg [5:0] words;
  reg [15:0] new_task_selector;
  reg [31:0] tss_base_hidden;
  reg [31:0] loaded_state [0:`STATE_WORDS-1];

  wire [2:0] kind;
  wire kind_call;
  wire kind_task;
  wire kind_32;

  gate_type_decoder decoder (
    .type_code(gate_word1[`TYPE_HI:`TYPE_LO]),
    .kind(kind),
    .is_call(kind_call),
    .is_task_gate(kind_task),
    .is_32bit(kind_32)
  );

  // ==========================================================================
  // Privilege comparisons
  // ==========================================================================
  // Numerically larger means less privileged, so plain unsigned compares work.
  wire [1:0] requested_privilege_level = xfer_selector[1:0];
  wire [1:0] gate_dpl = gate_word1[`DPL_HI:`DPL_LO];
  wire [1:0] eff_level = (requested_privilege_level > current_privilege_level) ? requested_privilege_level : current_privilege_level;
  wire gate_priv_ok = (eff_level <= gate_dpl);
  wire task_priv_ok = (requested_privilege_level < gate_dpl) && (current_privilege_level < gate_dpl);
  wire [1:0] dest_dpl = dest_word1[`DPL_HI:`DPL_LO];
  wire dest_conform = dest_word1[`SYS_BIT] && dest_word1[`TYPE_HI] && dest_word1[`CONFORM_BIT];
  wire dest_code = dest_word1[`SYS_BIT] && dest_word1[`TYPE_HI];
  wire dest_priv_ok = dest_conform ? (dest_dpl <= current_privilege_level) :
                      xfer_is_call ? (dest_dpl <= current_privilege_level) :
                      (dest_dpl == current_privilege_level);
  wire [3:0] tss_type = tss_word1[`TYPE_HI:`TYPE_LO];
  wire tss_type_ok = !tss_word1[`SYS_BIT] &&
                     ((tss_type == `TYPE_TSS32_AVAIL) || (tss_type == `TYPE_TSS16_AVAIL));
  wire ltr_ok = protected_mode && (current_privilege_level == 2'h0);
  wire ltr_global = !ltr_selector[`SEL_TI_BIT];
  // A gate is always a system descriptor. A code segment whose type bits
  // happen to read as a gate code must never be taken for a gate.
  wire gate_sys_ok = protected_mode && gate_word1[`PRESENT_BIT] && !gate_word1[`SYS_BIT];

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (xfer_start && gate_sys_ok && kind_call && gate_priv_ok)
          next_state = S_DEST;
        else if (xfer_start && gate_sys_ok && kind_task && task_priv_ok)
          next_state = S_TSSD;
      end
      // The destination descriptor may take any number of cycles to arrive.
      S_DEST: if (dest_ready) next_state = S_DONE;
      S_TSSD: if (tss_word1_valid) next_state = tss_type_ok ? S_SAVE : S_DONE;
      S_SAVE: if (state_index == words[4:0] - 5'h1) next_state = S_LOAD;
      S_LOAD: if (state_index == words[4:0] - 5'h1) next_state = S_DONE;
      S_DONE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // ==========================================================================
  // Sequencer and outputs
  // ==========================================================================
  // Target offset, parameter count, new level, back-link and the task pointer only move
  // on success, so an abort leaves them intact; gate_kind is set on every request.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      fault <= 1'b0;
      fault_code <= `FLT_NONE;
      gate_kind <= `KIND_NONE;
      dest_fetch <= 1'b0;
      dest_selector <= 16'h0000;
      target_offset <= 32'h00000000;
      param_copy_count <= 5'h00;
      new_privilege_level <= 2'h0;
      state_save <= 1'b0;
      state_load <= 1'b0;
      state_index <= 5'h00;
      save_data <= 32'h00000000;
      back_link <= 16'h0000;
      io_map_base <= `IOMAP_DEFAULT;
      task_pointer_register <= 16'h0000;
      tss_base_hidden <= 32'h00000000;
      str_value <= 16'h0000;
      str_valid <= 1'b0;
      is_tss32 <= 1'b0;
      words <= 6'h00;
      new_task_selector <= 16'h0000;
    end else begin
      state <= next_state;
      done <= 1'b0;
      fault <= 1'b0;
      str_valid <= 1'b0;
      dest_fetch <= 1'b0;
      case (state)
        S_IDLE: begin
          state_index <= 5'h00;
          if (xfer_start) begin
            gate_kind <= kind;
            if (!gate_sys_ok || !(kind_call || kind_task)) begin
              fault <= 1'b1;
              fault_code <= !protected_mode ? `FLT_NOT_PROT :
                            !gate_word1[`PRESENT_BIT] ? `FLT_NOT_PRESENT : `FLT_BAD_TYPE;
            end else if (kind_call && !gate_priv_ok) begin
              fault <= 1'b1;
              fault_code <= `FLT_GATE_PRIV;
            end else if (kind_task && !task_priv_ok) begin
              fault <= 1'b1;
              fault_code <= `FLT_TASK_PRIV;
            end else begin
              busy <= 1'b1;
              fault_code <= `FLT_NONE;
              if (kind_call) begin
                dest_fetch <= 1'b1;
                dest_selector <= gate_word0[31:16];
              end else begin
                new_task_selector <= {gate_word0[31:18], 2'b00};
              end
            end
          end else if (load_task_pointer_instr) begin
            if (ltr_ok && ltr_global) begin
              task_pointer_register <= ltr_selector;
              done <= 1'b1;
            end else begin
              fault <= 1'b1;
              fault_code <= !protected_mode ? `FLT_NOT_PROT :
                            !ltr_ok ? `FLT_LOAD_PRIV : `FLT_NOT_GLOBAL;
            end
          end else if (store_task_pointer_instr) begin
            if (protected_mode) begin
              str_value <= task_pointer_register;
              str_valid <= 1'b1;
            end else begin
              fault <= 1'b1;
              fault_code <= `FLT_NOT_PROT;
            end
          end
        end
        S_DEST: begin
          if (dest_ready) begin
            busy <= 1'b0;
            if (dest_code && dest_word1[`PRESENT_BIT] && dest_priv_ok) begin
              done <= 1'b1;
              target_offset <= {gate_word1[31:16], gate_word0[15:0]};
              param_copy_count <= gate_word1[`PARAM_HI:`PARAM_LO];
              new_privilege_level <= dest_conform ? current_privilege_level : dest_dpl;
            end else begin
              fault <= 1'b1;
              fault_code <= dest_word1[`PRESENT_BIT] ? `FLT_DEST_PRIV : `FLT_NOT_PRESENT;
            end
          end
        end
        S_TSSD: begin
          if (tss_word1_valid) begin
            is_tss32 <= tss_type[3];
            words <= tss_type[3] ? `TSS32_WORDS : `TSS16_WORDS;
            if (tss_type_ok) begin
              state_save <= 1'b1;
            end else begin
              busy <= 1'b0;
              fault <= 1'b1;
              fault_code <= `FLT_BAD_TYPE;
            end
          end
        end
        S_SAVE: begin
          save_data <= cur_state_word;
          if (state_index == words[4:0] - 5'h1) begin
            state_save <= 1'b0;
            state_load <= 1'b1;
            state_index <= 5'h00;
          end else begin
            state_index <= state_index + 5'h01;
          end
        end
        S_LOAD: begin
          if (state_index == words[4:0] - 5'h1) begin
            state_load <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            back_link <= task_pointer_register;
            task_pointer_register <= new_task_selector;
            tss_base_hidden <= tss_base;
            if (is_tss32)
              io_map_base <= loaded_state[0][31:16];
          end else begin
            state_index <= state_index + 5'h01;
          end
        end
        S_DONE: state_index <= 5'h00;
        default: busy <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Incoming task state capture
  // ==========================================================================
  // Word 0 is the top word of the segment; in the 32-bit layout it carries
  // the I/O map base, below it the selectors, registers and per-level stacks.
  genvar i;
  generate
    for (i = 0; i < `STATE_WORDS; i = i + 1) begin : capture
      always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
          loaded_state[i] <= 32'h00000000;
        else if (state == S_LOAD && state_index == i)
          loaded_state[i] <= new_state_word;
      end
    end
  endgenerate

endmodule

// >>> testbench/gate_task_protect_assertions.sv
/*
  Concurrent checks on the ports of the gate and task switch protection block.
  Assumes it is bound to the block's top module and shares the core clock.
*/
`timescale 1ns/1ps
`include "gate_task_regs.vh"
module gate_task_protect_assertions (
  input wire core_clk,
  input wire reset_n,
  input wire protected_mode,
  input wire [1:0] current_privilege_level,
  input wire xfer_start,
  input wire [31:0] gate_word0,
  input wire [31:0] gate_word1,
  input wire [31:0] cur_state_word,
  input wire load_task_pointer_instr,
  input wire [15:0] ltr_selector,
  input wire busy,
  input wire done,
  input wire fault,
  input wire [3:0] fault_code,
  input wire [2:0] gate_kind,
  input wire dest_fetch,
  input wire [15:0] dest_selector,
  input wire [31:0] target_offset,
  input wire [4:0] param_copy_count,
  input wire state_save,
  input wire state_load,
  input wire [31:0] save_data,
  input wire [15:0] task_pointer_register,
  input wire [15:0] str_value,
  input wire str_valid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Sequences
  // ==========================================================================
  sequence s_save_run;
    state_save [*8];
  endsequence
  sequence s_call_done;
    done && (gate_kind == `KIND_CALL16 || gate_kind == `KIND_CALL32);
  endsequence
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_done_fault_excl: assert property (!(done && fault))
    else $error("done and fault together");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_request_taken: assert property (xfer_start && !busy |=> busy || fault)
    else $error("transfer request not taken");
  a_fetch_selector: assert property (dest_fetch |-> dest_selector == gate_word0[31:16])
    else $error("wrong destination selector");
  a_offset_pair: assert property (s_call_done |-> target_offset == {gate_word1[31:16], gate_word0[15:0]})
    else $error("wrong target offset");
  a_param_copy: assert property (s_call_done |-> param_copy_count == gate_word1[4:0])
    else $error("wrong parameter count");
  a_load_level: assert property (load_task_pointer_instr && !busy && !xfer_start && protected_mode &&
    current_privilege_level != 2'h0 && !ltr_selector[2] |=> fault && fault_code == `FLT_LOAD_PRIV)
    else $error("load allowed above level 0");
  a_fault_keeps_tp: assert property (fault |-> $stable(task_pointer_register))
    else $error("task pointer changed on fault");
  a_save_burst: assert property ($rose(state_save) |-> s_save_run)
    else $error("state save burst too short");
  a_save_then_load: assert property ($fell(state_save) |-> state_load)
    else $error("load did not follow save");
  a_save_data: assert property ($past(state_save) |-> save_data == $past(cur_state_word))
    else $error("saved word mismatch");
  a_str_match: assert property (str_valid |-> str_value == task_pointer_register)
    else $error("stored selector mismatch");
endmodule

// >>> testbench/gate_and_task_switch_protection_tb_top.sv
/*
  Self-checking bench for the gate and task switch protection block.
  Assumes the block answers within a few dozen cycles and drives all inputs here.
*/
`timescale 1ns/1ps
`include "gate_task_regs.vh"
module gate_and_task_switch_protection_tb_top;
  reg core_clk = 1'b0;
  reg reset_n = 1'b0;
  reg protected_mode = 1'b1;
  reg [1:0] cur_pl = 2'h0;
  reg xfer_start = 1'b0;
  reg xfer_is_call = 1'b0;
  reg [15:0] xfer_selector = 16'h0;
  reg [31:0] gate_word0 = 32'h0;
  reg [31:0] gate_word1 = 32'h0;
  reg [31:0] dest_word1 = 32'h0;
  reg [31:0] tss_word1 = 32'h0;
  reg [31:0] cur_state_word = 32'h0;
  reg ld_tp = 1'b0;
  reg st_tp = 1'b0;
  reg [15:0] ltr_selector = 16'h0;
  reg [1:0] j;
  wire busy, done, fault, dest_fetch, state_save, state_load, str_valid;
  wire [3:0] fault_code;
  wire [2:0] gate_kind;
  wire [4:0] param_copy_count, state_index;
  wire [1:0] new_privilege_level;
  reg dest_rdy = 1'b0, fetch_d = 1'b0;
  // The new task's segment answers with its word index in bits 20:16, so a misplaced capture shows.
  wire [31:0] new_state_word = {11'h000, state_index, 16'h0000} | 32'h00a0_0000;
  wire [15:0] dest_selector, back_link, io_map_base, task_pointer_register, str_value;
  wire [31:0] target_offset, save_data;
  integer n_fail = 0, tests_run = 0, cycles = 0, n_save, n_load;
  gate_task_protect DUT (.core_clk(core_clk), .reset_n(reset_n), .protected_mode(protected_mode),
    .current_privilege_level(cur_pl), .xfer_start(xfer_start), .xfer_is_call(xfer_is_call),
    .xfer_selector(xfer_selector), .gate_word0(gate_word0), .gate_word1(gate_word1), .dest_ready(dest_rdy),
    .dest_word1(dest_word1), .tss_word1_valid(1'b1), .tss_word1(tss_word1), .tss_base(32'h0),
    .cur_state_word(cur_state_word), .new_state_word(new_state_word), .load_task_pointer_instr(ld_tp),
    .store_task_pointer_instr(st_tp), .ltr_selector(ltr_selector), .busy(busy), .done(done), .fault(fault),
    .fault_code(fault_code), .gate_kind(gate_kind), .dest_fetch(dest_fetch), .dest_selector(dest_selector),
    .target_offset(target_offset), .param_copy_count(param_copy_count), .new_privilege_level(new_privilege_level),
    .state_save(state_save), .state_load(state_load), .state_index(state_index), .save_data(save_data),
    .back_link(back_link), .io_map_base(io_map_base), .task_pointer_register(task_pointer_register),
    .str_value(str_value), .str_valid(str_valid));
  always #10 core_clk = ~core_clk;
  // A changing word lets the save path show a stuck register.
  always @(negedge core_clk) cur_state_word <= cur_state_word + 32'h1;
  // The destination descriptor arrives two cycles after the fetch, so the sequencer's wait is exercised.
  always @(negedge core_clk) begin
    fetch_d <= dest_fetch;
    dest_rdy <= fetch_d;
  end
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task report_and_stop;
    begin
      if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task go(input [1:0] k);
    integer i;
    begin
      if (k == 2'h0) xfer_start = 1'b1;
      else if (k == 2'h1) ld_tp = 1'b1;
      else st_tp = 1'b1;
      @(negedge core_clk);
      xfer_start = 1'b0;
      ld_tp = 1'b0;
      st_tp = 1'b0;
      n_save = 0;
      n_load = 0;
      // Outputs are looked at on the falling edge, where a one-cycle pulse from the request edge still stands.
      for (i = 0; i < 100; i = i + 1) begin
        if (state_save === 1'b1) n_save = n_save + 1;
        if (state_load === 1'b1) n_load = n_load + 1;
        if (done === 1'b1 || fault === 1'b1 || str_valid === 1'b1) i = 200;
        else @(negedge core_clk);
      end
      check(i, 201);
    end
  endtask
  task tp_op(input [1:0] k, input pm, input [1:0] c, input [15:0] sel, input [3:0] ef, input [15:0] ev);
    begin
      @(negedge core_clk);
      protected_mode = pm;
      cur_pl = c;
      ltr_selector = sel;
      go(k);
      check(fault, ef != 4'h0);
      if (ef != 4'h0) check(fault_code, ef);
      check(k == 2'h2 ? str_value : task_pointer_register, ev);
    end
  endtask
  task run_call(input [1:0] c, r, input k, input [1:0] gd, input [3:0] gt, input [1:0] dd, input cf,
    input [3:0] ef);
    reg [15:0] tp;
    begin
      @(negedge core_clk);
      tp = task_pointer_register;
      cur_pl = c;
      xfer_is_call = k;
      xfer_selector = {14'h4, r};
      dest_word1 = 32'h9a00 | (dd << 13) | (cf << 10);
      gate_word0 = 32'h0010_1234;
      gate_word1 = {16'hbeef, 1'b1, gd, 1'b0, gt, 8'h13};
      go(2'h0);
      check(fault, ef != 4'h0);
      if (ef != 4'h0) begin
        check(fault_code, ef);
        check(task_pointer_register, tp);
      end else begin
        check(target_offset, 32'hbeef_1234);
        check(param_copy_count, 5'h13);
        check(gate_kind, gt[3] ? `KIND_CALL32 : `KIND_CALL16);
        check(dest_selector, 16'h0010);
        check(new_privilege_level, cf ? c : dd);
      end
    end
  endtask
  task run_task(input [1:0] c, input [15:0] gsel, input [31:0] tw1, input [3:0] ef, input [5:0] n,
    input [15:0] etp);
    reg [15:0] old;
    begin
      @(negedge core_clk);
      old = task_pointer_register;
      cur_pl = c;
      xfer_is_call = 1'b1;
      xfer_selector = 16'h0058;
      tss_word1 = tw1;
      gate_word0 = {gsel, 16'h0};
      gate_word1 = 32'h0000_a500;
      go(2'h0);
      check(fault, ef != 4'h0);
      check(task_pointer_register, etp);
      if (ef != 4'h0) check(fault_code, ef);
      else begin
        check(n_save, n);
        check(n_load, n);
        check(state_index, n - 6'h1);
        check(back_link, old);
      end
    end
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    check(io_map_base, 16'h0068);
    check(task_pointer_register, 16'h0);
    tp_op(2'h1, 1'b1, 2'h3, 16'h0028, `FLT_LOAD_PRIV, 16'h0);
    tp_op(2'h1, 1'b1, 2'h0, 16'h002c, `FLT_NOT_GLOBAL, 16'h0);
    tp_op(2'h1, 1'b0, 2'h0, 16'h0028, `FLT_NOT_PROT, 16'h0);
    tp_op(2'h1, 1'b1, 2'h0, 16'h0028, `FLT_NONE, 16'h0028);
    tp_op(2'h2, 1'b1, 2'h3, 16'h0, `FLT_NONE, 16'h0028);
    tp_op(2'h2, 1'b0, 2'h0, 16'h0, `FLT_NOT_PROT, 16'h0028);
    protected_mode = 1'b1;
    run_call(2'h3, 2'h3, 1'b0, 2'h3, `TYPE_CALL32, 2'h3, 1'b0, `FLT_NONE);
    run_call(2'h2, 2'h3, 1'b1, 2'h2, `TYPE_CALL16, 2'h0, 1'b0, `FLT_GATE_PRIV);
    run_call(2'h3, 2'h0, 1'b1, 2'h3, `TYPE_CALL16, 2'h0, 1'b0, `FLT_NONE);
    run_call(2'h1, 2'h0, 1'b1, 2'h3, `TYPE_CALL32, 2'h2, 1'b0, `FLT_DEST_PRIV);
    run_call(2'h2, 2'h2, 1'b0, 2'h3, `TYPE_CALL32, 2'h1, 1'b0, `FLT_DEST_PRIV);
    run_call(2'h2, 2'h2, 1'b0, 2'h3, `TYPE_CALL32, 2'h1, 1'b1, `FLT_NONE);
    j = 2'h0;
    repeat (4) begin
      run_call(2'h0, 2'h0, 1'b1, 2'h3, {j[0], 2'b11, j[1]}, 2'h0, 1'b0, `FLT_BAD_TYPE);
      j = j + 2'h1;
    end
    @(negedge core_clk);
    gate_word1 = 32'hbeef_dc13;
    go(2'h0);
    check(fault, 1'b1);
    check(fault_code, `FLT_BAD_TYPE);
    run_task(2'h0, 16'h0033, 32'h0000_8900, `FLT_NONE, `TSS32_WORDS, 16'h0030);
    check(io_map_base, 16'h00a0);
    run_task(2'h0, 16'h0041, 32'h0000_8100, `FLT_NONE, `TSS16_WORDS, 16'h0040);
    check(io_map_base, 16'h00a0);
    run_task(2'h1, 16'h0050, 32'h0000_8900, `FLT_TASK_PRIV, 6'h0, 16'h0040);
    report_and_stop;
  end
endmodule
bind gate_task_protect gate_task_protect_assertions chk (.core_clk(core_clk), .reset_n(reset_n),
  .protected_mode(protected_mode), .current_privilege_level(current_privilege_level), .xfer_start(xfer_start),
  .gate_word0(gate_word0), .gate_word1(gate_word1), .cur_state_word(cur_state_word),
  .load_task_pointer_instr(load_task_pointer_instr), .ltr_selector(ltr_selector), .busy(busy), .done(done),
  .fault(fault), .fault_code(fault_code), .gate_kind(gate_kind), .dest_fetch(dest_fetch),
  .dest_selector(dest_selector), .target_offset(target_offset), .param_copy_count(param_copy_count),
  .state_save(state_save), .state_load(state_load), .save_data(save_data),
  .task_pointer_register(task_pointer_register), .str_value(str_value), .str_valid(str_valid));
